//--- hw/sfo_regs.sv
// Setup filter words and offset coefficients behind an AXI4-Lite slave
//
// Decided for this implementation: register access over AXI4-Lite.
`default_nettype none
// What this block does
// - Selector 0001 sinc4 averaging, 0010 sinc3 alone, 0100 sinc3 averaging; 1001-1111 reserved
// - Selector 0011 gives sinc3 plus extra notch at six fifths of main notch
// - Extra notch mode with divider 48 rejects 50 and 60 Hz at 50 SPS
// - Selectors 0101-1000 pick sinc3 with post filters 1 to 4, fixed rates
// - Each setup holds an 11-bit rate divider in low bits, reset 0x30
// - A rate divider value of zero behaves exactly as one
// - Eight 24-bit read-write offset coefficients, one per setup, at 0x29 to 0x30
// - Every offset coefficient resets to mid-scale 0x800000
// - Finished offset calibration writes result into the active channel's setup coefficient
// - Selector 0000 chooses sinc4 alone, no averaging, no added notch
module sfo_regs
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // AXI4-Lite write address and data
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   // AXI4-Lite write response
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   // AXI4-Lite read
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   // Calibration result
   input  wire logic        cal_done,
   input  wire logic [2:0]  cal_setup,
   input  wire logic [23:0] cal_offset,
   // Active setup and its decoded configuration
   input  wire logic [2:0]  active_setup,
   output logic             filt_sinc4,
   output logic             filt_average,
   output logic             sixty_hz_extra_notch,
   output logic [2:0]       post_filter,
   output logic             filt_reserved,
   output logic [10:0]      rate_divider_value,
   output logic             notch_50_60,
   output logic [23:0]      offset_coeff
);
   typedef struct packed {
      logic             aw_rdy;
      logic             aw_full;
      logic [7:0]       aw_addr;
      logic             w_rdy;
      logic             w_full;
      logic [31:0]      w_data;
      logic [3:0]       w_strb;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             ar_rdy;
      logic             rpend;
      logic             rpend_off;
      logic [15:0]      rpend_data;
      logic [1:0]       rpend_resp;
      logic             rvalid;
      logic [31:0]      rdata;
      logic [1:0]       rresp;
      logic [7:0][15:0] filt;
      logic             sinc4;
      logic             avg;
      logic             notch;
      logic [2:0]       post;
      logic             rsvd;
      logic [10:0]      rate;
      logic             n5060;
   } sfo_st_t;

   sfo_st_t          q;
   sfo_st_t          d;
   sfo_mem_if        mif ();
   sfo_pkg::sfo_dec_t wdec;
   sfo_pkg::sfo_dec_t rdec;
   logic [15:0]      fw;
   logic [10:0]      rd_raw;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode, shared by reads and writes
   function automatic sfo_pkg::sfo_dec_t sfo_decode(input logic [7:0] a);
      sfo_pkg::sfo_dec_t r;
      logic [5:0]        idx;
      idx     = a[7:2];
      r.hit   = 1'b0;
      r.off   = 1'b0;
      r.setup = 3'h0;
      if (idx >= sfo_pkg::FILT_IDX0 && idx <= sfo_pkg::FILT_IDX7)
      begin
         r.hit   = 1'b1;
         r.setup = 3'(idx - sfo_pkg::FILT_IDX0);
      end
      else if (idx >= sfo_pkg::OFFS_IDX0 && idx <= sfo_pkg::OFFS_IDX7)
      begin
         r.hit   = 1'b1;
         r.off   = 1'b1;
         r.setup = 3'(idx - sfo_pkg::OFFS_IDX0);
      end
      return r;
   endfunction : sfo_decode

   ////////////////////////////////////////////////////////////////////////////
   sfo_coef_mem u_mem
   (
      .clk     (clk),
      .reset_n (reset_n),
      .mp      (mif.mem)
   );

   assign wdec   = sfo_decode(q.aw_addr);
   assign rdec   = sfo_decode(araddr);
   assign fw     = q.filt[active_setup];
   assign rd_raw = fw[sfo_pkg::RD_MSB:0];

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      d = q;
      mif.we      = 1'b0;
      mif.waddr   = wdec.setup;
      mif.wbe     = q.w_strb[2:0];
      mif.wdata   = q.w_data[23:0];
      mif.raddr_a = rdec.setup;
      mif.raddr_b = active_setup;
      // Capture address and data independently, in either order
      if (awvalid && q.aw_rdy)
      begin
         d.aw_full = 1'b1;
         d.aw_addr = awaddr;
      end
      if (wvalid && q.w_rdy)
      begin
         d.w_full = 1'b1;
         d.w_data = wdata;
         d.w_strb = wstrb;
      end
      if (q.bvalid && bready)
      begin
         d.bvalid = 1'b0;
      end
      // Calibration owns the write port; a coinciding bus write waits a cycle
      if (cal_done)
      begin
         mif.we    = 1'b1;
         mif.waddr = cal_setup;
         mif.wbe   = 3'h7;
         mif.wdata = cal_offset;
      end
      else if (q.aw_full && q.w_full && !q.bvalid)
      begin
         d.aw_full = 1'b0;
         d.w_full  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = wdec.hit ? sfo_pkg::RESP_OKAY : sfo_pkg::RESP_SLVERR;
         if (wdec.hit && wdec.off)
         begin
            mif.we = 1'b1;
         end
         else if (wdec.hit)
         begin
            if (q.w_strb[0])
            begin
               d.filt[wdec.setup][7:0] = q.w_data[7:0];
            end
            if (q.w_strb[1])
            begin
               d.filt[wdec.setup][15:8] = q.w_data[15:8];
            end
            d.filt[wdec.setup][sfo_pkg::RSV_BIT] = 1'b0;
         end
      end
      // Reads: every word takes one pending cycle, the one offset words spend in the store's register
      if (arvalid && q.ar_rdy)
      begin
         d.rpend      = 1'b1;
         d.rpend_off  = rdec.off;
         d.rpend_data = (rdec.hit && !rdec.off) ? q.filt[rdec.setup] : 16'h0000;
         d.rpend_resp = rdec.hit ? sfo_pkg::RESP_OKAY : sfo_pkg::RESP_SLVERR;
      end
      if (q.rvalid && rready)
      begin
         d.rvalid = 1'b0;
      end
      if (q.rpend)
      begin
         d.rpend  = 1'b0;
         d.rvalid = 1'b1;
         d.rresp  = q.rpend_resp;
         d.rdata  = q.rpend_off ? {8'h00, mif.rdata_a} : {16'h0000, q.rpend_data};
      end
      d.aw_rdy = !d.aw_full;
      d.w_rdy  = !d.w_full;
      d.ar_rdy = !(d.rpend || d.rvalid);
      // Decode the active setup's filter word
      d.sinc4 = 1'b0;
      d.avg   = 1'b0;
      d.notch = 1'b0;
      d.post  = 3'h0;
      d.rsvd  = 1'b0;
      unique case (fw[15:sfo_pkg::FT_LSB])
         sfo_pkg::FT_SINC4:       d.sinc4 = 1'b1;
         sfo_pkg::FT_SINC4_AVG:
         begin
            d.sinc4 = 1'b1;
            d.avg   = 1'b1;
         end
         sfo_pkg::FT_SINC3:       d.sinc4 = 1'b0;
         sfo_pkg::FT_SINC3_NOTCH: d.notch = 1'b1;
         sfo_pkg::FT_SINC3_AVG:   d.avg   = 1'b1;
         sfo_pkg::FT_SINC3_PF1:   d.post  = 3'h1;
         sfo_pkg::FT_SINC3_PF2:   d.post  = 3'h2;
         sfo_pkg::FT_SINC3_PF3:   d.post  = 3'h3;
         sfo_pkg::FT_SINC3_PF4:   d.post  = 3'h4;
         default:                 d.rsvd  = 1'b1;
      endcase
      d.rate  = (rd_raw == 11'h000) ? 11'h001 : rd_raw;
      d.n5060 = (fw[15:sfo_pkg::FT_LSB] == sfo_pkg::FT_SINC3_NOTCH)
                && (d.rate == sfo_pkg::RD_50HZ);
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         q        <= '0;
         q.aw_rdy <= 1'b1;
         q.w_rdy  <= 1'b1;
         q.ar_rdy <= 1'b1;
         q.filt   <= {sfo_pkg::NUM_SETUPS{sfo_pkg::FT_RST, 1'b0, sfo_pkg::RD_RST}};
      end
      else
      begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign awready              = q.aw_rdy;
   assign wready               = q.w_rdy;
   assign bvalid               = q.bvalid;
   assign bresp                = q.bresp;
   assign arready              = q.ar_rdy;
   assign rvalid               = q.rvalid;
   assign rdata                = q.rdata;
   assign rresp                = q.rresp;
   assign filt_sinc4           = q.sinc4;
   assign filt_average         = q.avg;
   assign sixty_hz_extra_notch = q.notch;
   assign post_filter          = q.post;
   assign filt_reserved        = q.rsvd;
   assign rate_divider_value   = q.rate;
   assign notch_50_60          = q.n5060;
   assign offset_coeff         = mif.rdata_b;

   ////////////////////////////////////////////////////////////////////////////
   sinc4_alone_a:
   assert property (@(posedge clk) disable iff (!reset_n)
      (fw[15:12] == 4'h0) |=> (filt_sinc4 && !filt_average && !sixty_hz_extra_notch
                               && post_filter == 3'h0))
      else $error("sinc4 alone decode wrong");

   filt_avg_a:
   assert property (@(posedge clk) disable iff (!reset_n)
      (fw[15:12] == 4'h1 || fw[15:12] == 4'h4) |=> filt_average
      && (filt_sinc4 == ($past(fw[15:12]) == 4'h1)))
      else $error("averaging decode wrong");

   extra_notch_a:
   assert property (@(posedge clk) disable iff (!reset_n)
      (fw[15:12] == 4'h3) |=> (sixty_hz_extra_notch && !filt_sinc4 && !filt_average))
      else $error("extra notch decode wrong");

   reject_both_a:
   assert property (@(posedge clk) disable iff (!reset_n)
      (fw[15:12] == 4'h3 && fw[10:0] == 11'h030) |=> notch_50_60)
      else $error("50/60 Hz rejection not flagged");

   post_sel_a:
   assert property (@(posedge clk) disable iff (!reset_n)
      (fw[15:12] >= 4'h5 && fw[15:12] <= 4'h8)
      |=> (post_filter == 3'($past(fw[15:12]) - 4'h4)) && !filt_sinc4)
      else $error("post filter decode wrong");

   rate_pass_a:
   assert property (@(posedge clk) disable iff (!reset_n)
      (rd_raw != 11'h000) |=> (rate_divider_value == $past(rd_raw)))
      else $error("rate divider not passed");

   rate_zero_a:
   assert property (@(posedge clk) disable iff (!reset_n)
      (rd_raw == 11'h000) |=> (rate_divider_value == 11'h001))
      else $error("zero divider not treated as one");

   cal_store_a:
   assert property (@(posedge clk) disable iff (!reset_n)
      cal_done ##1 (active_setup == $past(cal_setup) && !cal_done)
      |=> (offset_coeff == $past(cal_offset, 2)))
      else $error("calibration result not stored");

   rsvd_zero_a:
   assert property (@(posedge clk) disable iff (!reset_n)
      (q.rpend && !q.rpend_off) |=> !rdata[11])
      else $error("reserved filter bit reads one");
endmodule : sfo_regs
`default_nettype wire

//--- inc/sfo_pkg.sv
// Constants and types shared by the setup filter and offset register bank
`default_nettype none
package sfo_pkg;
   // Bus geometry; printed offsets are word indices, byte address is four times
   localparam int          ADDR_W      = 8;
   localparam int          NUM_SETUPS  = 8;
   localparam logic [5:0]  FILT_IDX0   = 6'h19;
   localparam logic [5:0]  FILT_IDX7   = 6'h20;
   localparam logic [5:0]  OFFS_IDX0   = 6'h29;
   localparam logic [5:0]  OFFS_IDX7   = 6'h30;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   // Filter word layout (low 16 bits of each setup's filter word)
   localparam int          FT_LSB      = 12;
   localparam int          RSV_BIT     = 11;
   localparam int          RD_MSB      = 10;
   // Reset values
   localparam logic [3:0]  FT_RST      = 4'h2;
   localparam logic [10:0] RD_RST      = 11'h030;
   localparam logic [23:0] OFFS_RST    = 24'h800000;
   // Rate divider value that puts the main notch at 50 Hz, giving 50 SPS
   localparam logic [10:0] RD_50HZ     = 11'h030;
   // Fixed output rates of the post filters, in milli samples per second
   localparam int          PF1_ODR_MSPS = 26087;
   localparam int          PF2_ODR_MSPS = 24000;
   localparam int          PF3_ODR_MSPS = 19355;
   localparam int          PF4_ODR_MSPS = 16210;
   // Filter type selector codes
   typedef enum logic [3:0] {
      FT_SINC4       = 4'b0000,
      FT_SINC4_AVG   = 4'b0001,
      FT_SINC3       = 4'b0010,
      FT_SINC3_NOTCH = 4'b0011,
      FT_SINC3_AVG   = 4'b0100,
      FT_SINC3_PF1   = 4'b0101,
      FT_SINC3_PF2   = 4'b0110,
      FT_SINC3_PF3   = 4'b0111,
      FT_SINC3_PF4   = 4'b1000
   } sfo_ftype_t;
   // Result of decoding a bus address
   typedef struct packed {
      logic       hit;
      logic       off;
      logic [2:0] setup;
   } sfo_dec_t;
endpackage : sfo_pkg
`default_nettype wire

//--- inc/sfo_mem_if.sv
// Link between the register logic and the offset coefficient store
`default_nettype none
interface sfo_mem_if;
   logic        we;
   logic [2:0]  waddr;
   logic [2:0]  wbe;
   logic [23:0] wdata;
   logic [2:0]  raddr_a;
   logic [23:0] rdata_a;
   logic [2:0]  raddr_b;
   logic [23:0] rdata_b;
   modport mem  (input we, waddr, wbe, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
   modport user (output we, waddr, wbe, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
endinterface : sfo_mem_if
`default_nettype wire

//--- hw/sfo_coef_mem.sv
// Eight 24-bit offset coefficients with byte write enables and two registered reads
`default_nettype none
module sfo_coef_mem
(
   // Clock and reset
   input  wire logic     clk,
   input  wire logic     reset_n,
   // Access port
   sfo_mem_if.mem        mp
);
   typedef struct packed {
      logic [7:0][23:0] word;
      logic [23:0]      ra;
      logic [23:0]      rb;
   } sfo_mem_st_t;

   sfo_mem_st_t q;
   sfo_mem_st_t d;

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      d = q;
      // Reads see the old word during a write to the same setup
      d.ra = q.word[mp.raddr_a];
      d.rb = q.word[mp.raddr_b];
      for (int b = 0; b < 3; b++)
      begin
         if (mp.we && mp.wbe[b])
         begin
            d.word[mp.waddr][b*8 +: 8] = mp.wdata[b*8 +: 8];
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         q.word <= {sfo_pkg::NUM_SETUPS{sfo_pkg::OFFS_RST}};
         q.ra   <= 24'h000000;
         q.rb   <= 24'h000000;
      end
      else
      begin
         q <= d;
      end
   end

   assign mp.rdata_a = q.ra;
   assign mp.rdata_b = q.rb;

   ////////////////////////////////////////////////////////////////////////////
   mem_write_a:
   assert property (@(posedge clk) disable iff (!reset_n)
      (mp.we && mp.wbe == 3'h7) |=> (q.word[$past(mp.waddr)] == $past(mp.wdata)))
      else $error("offset word not stored");
endmodule : sfo_coef_mem
`default_nettype wire

//--- sim/sfo_cal_host.sv
// Behavioural calibration engine handing offset results to the bank
`default_nettype none
module sfo_cal_host
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Request from the bench
   input  wire logic        go,
   input  wire logic [2:0]  setup,
   input  wire logic [23:0] value,
   input  wire logic [7:0]  lat,
   // Result to the bank
   output logic             cal_done,
   output logic [2:0]       cal_setup,
   output logic [23:0]      cal_offset
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] cnt_q;
   ////////////////////////////////////////////////////////////////////////////////
   // One setup index per run: only one channel is active while calibrating
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt_q      <= 8'h00;
         cal_done   <= 1'b0;
         cal_setup  <= 3'h0;
         cal_offset <= 24'h000000;
      end
      else
      begin
         cal_done <= (cnt_q == 8'h01);
         if (go)
            cnt_q <= lat;
         else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
         if (cnt_q == 8'h01)
         begin
            cal_setup  <= setup;
            cal_offset <= value;
         end
         else
         begin
            // Not valid outside the pulse, so keep it moving
            cal_setup  <= ~cal_setup;
            cal_offset <= ~cal_offset;
         end
      end
   end
endmodule : sfo_cal_host
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the setup filter and offset register bank
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, cal_done, go;
   logic sinc4, avg, notch, rsv, n5060;
   logic [7:0] awaddr, araddr, lat;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic [2:0] cal_setup, active_setup, pf, g_setup;
   logic [23:0] cal_offset, g_value, ocoef;
   logic [10:0] rdv;
   int miscompares = 0;
   int n_compared = 0;
   sfo_regs uut (.clk(clk), .reset_n(reset_n), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .cal_done(cal_done), .cal_setup(cal_setup),
      .cal_offset(cal_offset), .active_setup(active_setup), .filt_sinc4(sinc4),
      .filt_average(avg), .sixty_hz_extra_notch(notch), .post_filter(pf),
      .filt_reserved(rsv), .rate_divider_value(rdv), .notch_50_60(n5060),
      .offset_coeff(ocoef));
   sfo_cal_host host (.clk(clk), .reset_n(reset_n), .go(go), .setup(g_setup),
      .value(g_value), .lat(lat), .cal_done(cal_done), .cal_setup(cal_setup),
      .cal_offset(cal_offset));
   always #12.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   // Both channels offered together; each dropped once its own ready is seen
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      bit done;
      done = 0;
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      // No cycle count is assumed; only the watchdog ends a wait without answer
      while (!done)
      begin
         @(posedge clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         done = bvalid;
         rs = bresp;
      end
      bready <= 1'b0;
      @(posedge clk);
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      bit done;
      done = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done)
      begin
         @(posedge clk);
         if (arready)
            arvalid <= 1'b0;
         done = rvalid;
         v = rdata;
         rs = rresp;
      end
      rready <= 1'b0;
      @(posedge clk);
   endtask : axi_rd
   function automatic logic [7:0] baddr(input logic [5:0] idx);
      return {idx, 2'b00};
   endfunction : baddr
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      for (int n = 0; n < 8; n++)
      begin
         axi_rd(baddr(sfo_pkg::OFFS_IDX0 + 6'(n)), d, r);
         chk(d, 32'h00800000);
         axi_rd(baddr(sfo_pkg::FILT_IDX0 + 6'(n)), d, r);
         chk(d, 32'h00002030);
      end
      axi_rd(8'h00, d, r);
      chk(32'(r), 32'(sfo_pkg::RESP_SLVERR));
      chk(d, 32'h0);
      axi_wr(8'h00, 32'h12345678, r);
      chk(32'(r), 32'(sfo_pkg::RESP_SLVERR));
   endtask : t_reset
   // Each setup gets a distinct word so a mis-decoded index shows up
   task automatic t_offsets();
      for (int n = 0; n < 8; n++)
      begin
         axi_wr(baddr(sfo_pkg::OFFS_IDX0 + 6'(n)), 32'hFF123450 + 32'(n), r);
         chk(32'(r), 32'(sfo_pkg::RESP_OKAY));
      end
      for (int n = 0; n < 8; n++)
      begin
         axi_rd(baddr(sfo_pkg::OFFS_IDX0 + 6'(n)), d, r);
         chk(32'(r), 32'(sfo_pkg::RESP_OKAY));
         chk(d, 32'h00123450 + 32'(n));
      end
   endtask : t_offsets
   // Last pass repeats the notch code with another divider: no 50/60 Hz flag then
   task automatic t_filter();
      logic [10:0] dv;
      logic [3:0] c;
      active_setup <= 3'h3;
      for (int k = 0; k < 17; k++)
      begin
         c = (k == 16) ? 4'h3 : 4'(k);
         dv = (k == 3) ? sfo_pkg::RD_50HZ : 11'(k);
         axi_wr(baddr(sfo_pkg::FILT_IDX0 + 6'h3), {16'h0, c, 1'b1, dv}, r);
         axi_rd(baddr(sfo_pkg::FILT_IDX0 + 6'h3), d, r);
         chk(d, {16'h0, c, 1'b0, dv});
         repeat (2) @(posedge clk);
         chk(32'({sinc4, avg}), 32'({c < 4'h2, c == 4'h1 || c == 4'h4}));
         chk(32'(notch), 32'(c == 4'h3));
         chk(32'(n5060), 32'(c == 4'h3 && dv == sfo_pkg::RD_50HZ));
         chk(32'({pf, rsv}), 32'({(c > 4'h4 && c < 4'h9) ? 3'(c - 4'h4) : 3'h0, c > 4'h8}));
         chk(32'(rdv), 32'((dv == 11'h0) ? 11'h1 : dv));
      end
   endtask : t_filter
   // Bus write to another setup meets the calibration store and has to wait
   task automatic t_cal();
      g_setup <= 3'h5;
      g_value <= 24'hA5C3E1;
      lat <= 8'h01;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      active_setup <= 3'h5;
      axi_wr(baddr(sfo_pkg::OFFS_IDX0 + 6'h6), 32'h00654321, r);
      chk(32'(r), 32'(sfo_pkg::RESP_OKAY));
      chk(32'(ocoef), 32'h00A5C3E1);
      axi_rd(baddr(sfo_pkg::OFFS_IDX0 + 6'h5), d, r);
      chk(d, 32'h00A5C3E1);
      axi_rd(baddr(sfo_pkg::OFFS_IDX0 + 6'h6), d, r);
      chk(d, 32'h00654321);
   endtask : t_cal
   // A reset in mid-run must bring back the defaults of offset 5 and filter word 3 over written values
   task automatic t_rereset();
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      axi_rd(baddr(sfo_pkg::OFFS_IDX0 + 6'h5), d, r);
      chk(d, 32'(sfo_pkg::OFFS_RST));
      axi_rd(baddr(sfo_pkg::FILT_IDX0 + 6'h3), d, r);
      chk(d, {16'h0, sfo_pkg::FT_RST, 1'b0, sfo_pkg::RD_RST});
      chk(32'(rdv), 32'(sfo_pkg::RD_RST));
   endtask : t_rereset
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 0;
      reset_n = 0;
      {awvalid, wvalid, bready, arvalid, rready, go} <= '0;
      {awaddr, araddr, wdata, wstrb, active_setup, g_setup, g_value, lat} <= '0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_offsets();
      t_filter();
      t_cal();
      t_rereset();
      end_sim();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
